// ### verilog/scmac_pkg.sv
// constants, types and layouts shared by the command-mode interpreter
package scmac_pkg;
    // clock and time figures
    localparam int CLK_PERIOD_NS = 4;
    localparam int WINDOW_MS = 10;
    localparam int WINDOW_CYC = WINDOW_MS * 1000000 / CLK_PERIOD_NS;
    localparam int RESP_US = 100;
    localparam int RESP_CYC = RESP_US * 1000 / CLK_PERIOD_NS;
    localparam int WRITE_MS = 12;
    localparam int WRITE_CYC = WRITE_MS * 1000000 / CLK_PERIOD_NS;
    localparam int CNT_W = 22;
    // cycles from reset release until the stored address is loaded
    localparam logic [1:0] BOOT_CYC = 2'h2;

    // configuration memory layout
    localparam int MEM_WORDS = 32;
    localparam int MEM_AW = 5;
    localparam int WORD_W = 16;
    localparam logic [4:0] CFG_ADDR_IDX = 5'h1c;
    localparam logic [6:0] FACTORY_ADDR = 7'h28;
    localparam logic [15:0] CFG_WORD_RESET = 16'h0028;
    localparam logic [15:0] WORD_RESET = 16'h0000;

    // command bytes and groups
    localparam logic [7:0] CMD_ENTER = 8'ha0;
    localparam logic [7:0] CMD_RESUME = 8'h80;
    localparam logic [7:0] CMD_REV = 8'hb0;
    localparam logic [2:0] READ_GRP = 3'h0;
    localparam logic [2:0] WRITE_GRP = 3'h2;

    // response byte codes
    localparam logic [1:0] ST_NORMAL = 2'h0;
    localparam logic [1:0] ST_STALE = 2'h1;
    localparam logic [1:0] ST_CMD = 2'h2;
    localparam logic [1:0] RESP_BUSY = 2'h0;
    localparam logic [1:0] RESP_ACK = 2'h1;
    localparam logic [1:0] RESP_NACK = 2'h2;

    // serial framing
    localparam logic [3:0] BIT_END = 4'h8;
    localparam logic [2:0] MSG_DATA_BYTES = 3'h3;
    localparam logic [1:0] FETCH_LAST = 2'h3;

    typedef enum logic [2:0] {
        I2C_IDLE = 3'b000,
        I2C_ADDR = 3'b001,
        I2C_AACK = 3'b010,
        I2C_RX = 3'b011,
        I2C_RACK = 3'b100,
        I2C_TX = 3'b101,
        I2C_TACK = 3'b110
    } scmac_i2c_st_t;

    typedef enum logic [1:0] {
        OP_NONE = 2'b00,
        OP_READ = 2'b01,
        OP_WRITE = 2'b10,
        OP_REV = 2'b11
    } scmac_op_t;

    typedef struct packed {
        logic [1:0] status;
        logic [3:0] diag;
        logic [1:0] resp;
    } scmac_status_t;
endpackage

// ### verilog/scmac_cfg_mem.sv
// configuration word store with registered read data
`timescale 1ns/1ps
`default_nettype none
module scmac_cfg_mem #(
    parameter int DEPTH = scmac_pkg::MEM_WORDS,
    parameter int AW = scmac_pkg::MEM_AW,
    parameter int DW = scmac_pkg::WORD_W
) (
    // clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // write side
    input wire logic we,
    input wire logic [AW-1:0] wAddr,
    input wire logic [DW-1:0] wData,
    // read side
    input wire logic [AW-1:0] rAddr,
    output logic [DW-1:0] rData
);
    import scmac_pkg::*;

    // words live through reset like the eeprom they stand for; factory
    // content is only their start value, the address word holds 0x28
    logic [DW-1:0] mem [DEPTH] = '{CFG_ADDR_IDX: DW'(CFG_WORD_RESET),
        default: DW'(WORD_RESET)};

    // only a write changes a word, so a new address survives power-on
    genvar i;
    generate
        for (i = 0; i < DEPTH; i++) begin : gWord
            always_ff @(posedge mclk) begin
                if (we && wAddr == AW'(i)) begin
                    mem[i] <= wData;
                end
            end
        end
    endgenerate

    // read data lags the address by one cycle
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            rData <= '0;
        end else begin
            rData <= mem[rAddr];
        end
    end
endmodule // scmac_cfg_mem
`default_nettype wire

// ### verilog/scmac_cmd_interp.sv
// i2c slave with command-mode interpreter and address change
`timescale 1ns/1ps
`default_nettype none
module scmac_cmd_interp #(
    parameter int WINDOW_CYCLES = scmac_pkg::WINDOW_CYC,
    parameter int RESP_CYCLES = scmac_pkg::RESP_CYC,
    parameter int WRITE_CYCLES = scmac_pkg::WRITE_CYC,
    // revision value is arbitrary
    parameter logic [15:0] REVISION = 16'h0001
) (
    // clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // i2c pins
    input wire logic scl,
    input wire logic sdaIn,
    output logic sdaOut,
    output logic sdaOeN,
    // fault sources, same clock
    input wire logic [3:0] faultFlags,
    // mode and address state
    output logic cmdModeActive,
    output logic [6:0] busAddr
);
    import scmac_pkg::*;

    // every assertion below runs on mclk and rests during reset
    default clocking cbAst @(posedge mclk);
    endclocking
    default disable iff (!rst_n);

    logic sclMeta, sclSync, sclPrev, sdaMeta, sdaSync, sdaPrev;
    logic sclRise, sclFall, startCond, stopCond;
    scmac_i2c_st_t i2cState, next_i2cState;
    logic [3:0] bitCnt, next_bitCnt;
    logic [7:0] shiftReg, next_shiftReg, txShift, next_txShift;
    logic rwBit, next_rwBit, next_sdaOeN;
    logic [2:0] rxCnt, next_rxCnt;
    logic [7:0] cmdByte, next_cmdByte, dataHi, next_dataHi;
    logic [7:0] dataLo, next_dataLo, txByte;
    logic [1:0] fetchIdx, next_fetchIdx;
    logic execPulse, next_execPulse, statusFetched, next_statusFetched;
    scmac_status_t statusByte;
    logic next_cmdMode, stale, next_stale, memWe, next_memWe;
    logic [CNT_W-1:0] windowCnt, next_windowCnt, busyCnt, next_busyCnt;
    scmac_op_t pendOp, next_pendOp;
    logic [4:0] pendIdx, next_pendIdx;
    logic [15:0] pendData, next_pendData, respData, next_respData;
    logic [15:0] memRData;
    logic [1:0] respCode, next_respCode;
    logic [6:0] next_busAddr, shadowAddr, next_shadowAddr;
    logic [3:0] faultReg;
    logic [1:0] bootCnt, next_bootCnt;

    // pins pass two flops; edges compare second and third stage only
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            sclMeta <= 1'b1;
            sclSync <= 1'b1;
            sclPrev <= 1'b1;
            sdaMeta <= 1'b1;
            sdaSync <= 1'b1;
            sdaPrev <= 1'b1;
            sdaOut <= 1'b0;
        end else begin
            sclMeta <= scl;
            sclSync <= sclMeta;
            sclPrev <= sclSync;
            sdaMeta <= sdaIn;
            sdaSync <= sdaMeta;
            sdaPrev <= sdaSync;
            sdaOut <= 1'b0; // open drain: only ever pulls low
        end
    end

    assign sclRise = sclSync & ~sclPrev;
    assign sclFall = ~sclSync & sclPrev;
    assign startCond = sclSync & sclPrev & sdaPrev & ~sdaSync;
    assign stopCond = sclSync & sclPrev & ~sdaPrev & sdaSync;

    // first response byte and fetch byte order
    always_comb begin
        statusByte.status = cmdModeActive ? ST_CMD
                          : (stale ? ST_STALE : ST_NORMAL);
        statusByte.diag = faultReg;
        statusByte.resp = respCode;
        case (fetchIdx)
            2'h0: txByte = statusByte;
            2'h1: txByte = respData[15:8];
            2'h2: txByte = respData[7:0];
            default: txByte = 8'h00;
        endcase
    end

    // serial engine: sample on scl rise, change sda on scl fall
    always_comb begin
        next_i2cState = i2cState;
        next_bitCnt = bitCnt;
        next_shiftReg = shiftReg;
        next_txShift = txShift;
        next_rwBit = rwBit;
        next_sdaOeN = sdaOeN;
        next_rxCnt = rxCnt;
        next_cmdByte = cmdByte;
        next_dataHi = dataHi;
        next_dataLo = dataLo;
        next_fetchIdx = fetchIdx;
        next_execPulse = 1'b0;
        next_statusFetched = 1'b0;
        if (startCond) begin
            next_i2cState = I2C_ADDR;
            next_bitCnt = 4'h0;
            next_sdaOeN = 1'b1;
        end else if (stopCond) begin
            // only a complete four-byte write runs a command
            // the stop's own scl rise has already counted one bit
            if (i2cState == I2C_RX && bitCnt <= 4'h1
                    && rxCnt == MSG_DATA_BYTES) begin
                next_execPulse = 1'b1;
            end
            next_i2cState = I2C_IDLE;
            next_sdaOeN = 1'b1;
        end else begin
            case (i2cState)
                I2C_ADDR: begin
                    if (sclRise) begin
                        next_shiftReg = {shiftReg[6:0], sdaSync};
                        next_bitCnt = bitCnt + 4'h1;
                    end else if (sclFall && bitCnt == BIT_END) begin
                        // answers on the active address only
                        if (shiftReg[7:1] == busAddr) begin
                            next_i2cState = I2C_AACK;
                            next_sdaOeN = 1'b0;
                            next_rwBit = shiftReg[0];
                        end else begin
                            next_i2cState = I2C_IDLE;
                        end
                    end
                end
                I2C_AACK: begin
                    if (sclFall) begin
                        next_bitCnt = 4'h0;
                        next_fetchIdx = 2'h0;
                        next_rxCnt = 3'h0;
                        if (rwBit) begin
                            next_i2cState = I2C_TX;
                            next_txShift = statusByte;
                            next_sdaOeN = statusByte[7];
                        end else begin
                            next_i2cState = I2C_RX;
                            next_sdaOeN = 1'b1;
                        end
                    end
                end
                I2C_RX: begin
                    if (sclRise) begin
                        next_shiftReg = {shiftReg[6:0], sdaSync};
                        next_bitCnt = bitCnt + 4'h1;
                    end else if (sclFall && bitCnt == BIT_END) begin
                        next_i2cState = I2C_RACK;
                        next_sdaOeN = 1'b0;
                        case (rxCnt)
                            3'h0: next_cmdByte = shiftReg;
                            3'h1: next_dataHi = shiftReg;
                            3'h2: next_dataLo = shiftReg;
                            default: next_dataLo = dataLo;
                        endcase
                        // saturate so long messages never alias to four
                        if (rxCnt != 3'h7) begin
                            next_rxCnt = rxCnt + 3'h1;
                        end
                    end
                end
                I2C_RACK: begin
                    if (sclFall) begin
                        next_i2cState = I2C_RX;
                        next_sdaOeN = 1'b1;
                        next_bitCnt = 4'h0;
                    end
                end
                I2C_TX: begin
                    if (sclRise) begin
                        next_bitCnt = bitCnt + 4'h1;
                    end else if (sclFall) begin
                        if (bitCnt == BIT_END) begin
                            next_i2cState = I2C_TACK;
                            next_sdaOeN = 1'b1;
                        end else begin
                            next_txShift = {txShift[6:0], 1'b0};
                            next_sdaOeN = txShift[6];
                        end
                    end
                end
                I2C_TACK: begin
                    if (sclRise) begin
                        if (fetchIdx == 2'h0) begin
                            next_statusFetched = 1'b1;
                        end
                        if (sdaSync) begin
                            next_i2cState = I2C_IDLE;
                        end else if (fetchIdx != FETCH_LAST) begin
                            next_fetchIdx = fetchIdx + 2'h1;
                        end
                    end else if (sclFall) begin
                        next_i2cState = I2C_TX;
                        next_bitCnt = 4'h0;
                        next_txShift = txByte;
                        next_sdaOeN = txByte[7];
                    end
                end
                default: next_i2cState = I2C_IDLE;
            endcase
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            i2cState <= I2C_IDLE;
            bitCnt <= 4'h0;
            shiftReg <= 8'h00;
            txShift <= 8'h00;
            rwBit <= 1'b0;
            sdaOeN <= 1'b1;
            rxCnt <= 3'h0;
            cmdByte <= 8'h00;
            dataHi <= 8'h00;
            dataLo <= 8'h00;
            fetchIdx <= 2'h0;
            execPulse <= 1'b0;
            statusFetched <= 1'b0;
        end else begin
            i2cState <= next_i2cState;
            bitCnt <= next_bitCnt;
            shiftReg <= next_shiftReg;
            txShift <= next_txShift;
            rwBit <= next_rwBit;
            sdaOeN <= next_sdaOeN;
            rxCnt <= next_rxCnt;
            cmdByte <= next_cmdByte;
            dataHi <= next_dataHi;
            dataLo <= next_dataLo;
            fetchIdx <= next_fetchIdx;
            execPulse <= next_execPulse;
            statusFetched <= next_statusFetched;
        end
    end

    // command interpreter; a message arriving while busy is dropped
    always_comb begin
        next_cmdMode = cmdModeActive;
        next_windowCnt = windowCnt;
        next_busyCnt = busyCnt;
        next_pendOp = pendOp;
        next_pendIdx = pendIdx;
        next_pendData = pendData;
        next_respCode = respCode;
        next_respData = respData;
        next_stale = stale;
        next_busAddr = busAddr;
        next_shadowAddr = shadowAddr;
        next_memWe = 1'b0;
        next_bootCnt = bootCnt;
        // stored address returns from the word store after power-on
        if (bootCnt != 2'h0) begin
            next_bootCnt = bootCnt - 2'h1;
            if (bootCnt == 2'h1) begin
                next_busAddr = memRData[6:0];
                next_shadowAddr = memRData[6:0];
            end
        end
        if (windowCnt != '0) begin
            next_windowCnt = windowCnt - CNT_W'(1);
        end
        if (statusFetched) begin
            next_stale = 1'b1;
        end
        if (busyCnt != '0) begin
            next_busyCnt = busyCnt - CNT_W'(1);
            if (busyCnt == CNT_W'(1)) begin
                // completion beats a fetch in the same cycle
                next_stale = 1'b0;
                next_respCode = RESP_ACK;
                next_pendOp = OP_NONE;
                case (pendOp)
                    OP_READ: next_respData = memRData;
                    OP_WRITE: begin
                        next_memWe = 1'b1;
                        next_respData = 16'h0000;
                        if (pendIdx == CFG_ADDR_IDX) begin
                            next_shadowAddr = pendData[6:0];
                        end
                    end
                    OP_REV: next_respData = REVISION;
                    default: next_respCode = RESP_NACK;
                endcase
            end
        end else if (execPulse) begin
            if (!cmdModeActive) begin
                // late entry leaves the module in normal operation
                if (cmdByte == CMD_ENTER && windowCnt != '0) begin
                    next_cmdMode = 1'b1;
                    next_respCode = RESP_ACK;
                    next_respData = 16'h0000;
                    next_stale = 1'b0;
                end
            end else begin
                next_stale = 1'b0;
                next_respData = 16'h0000;
                next_pendIdx = cmdByte[4:0];
                if (cmdByte[7:5] == READ_GRP) begin
                    next_pendOp = OP_READ;
                    next_busyCnt = CNT_W'(RESP_CYCLES);
                    next_respCode = RESP_BUSY;
                end else if (cmdByte[7:5] == WRITE_GRP) begin
                    next_pendOp = OP_WRITE;
                    next_pendData = {dataHi, dataLo};
                    next_busyCnt = CNT_W'(WRITE_CYCLES);
                    next_respCode = RESP_BUSY;
                end else if (cmdByte == CMD_REV) begin
                    next_pendOp = OP_REV;
                    next_busyCnt = CNT_W'(RESP_CYCLES);
                    next_respCode = RESP_BUSY;
                end else if (cmdByte == CMD_RESUME) begin
                    next_cmdMode = 1'b0;
                    next_busAddr = shadowAddr;
                    next_respCode = RESP_ACK;
                end else if (cmdByte == CMD_ENTER) begin
                    next_respCode = RESP_ACK;
                end else begin
                    next_respCode = RESP_NACK;
                end
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            cmdModeActive <= 1'b0;
            windowCnt <= CNT_W'(WINDOW_CYCLES);
            busyCnt <= '0;
            pendOp <= OP_NONE;
            pendIdx <= CFG_ADDR_IDX; // boot reads the address word
            bootCnt <= BOOT_CYC;
            pendData <= 16'h0000;
            respCode <= RESP_BUSY;
            respData <= 16'h0000;
            stale <= 1'b0;
            busAddr <= FACTORY_ADDR;
            shadowAddr <= FACTORY_ADDR;
            memWe <= 1'b0;
            faultReg <= 4'h0;
        end else begin
            cmdModeActive <= next_cmdMode;
            windowCnt <= next_windowCnt;
            busyCnt <= next_busyCnt;
            pendOp <= next_pendOp;
            pendIdx <= next_pendIdx;
            pendData <= next_pendData;
            respCode <= next_respCode;
            respData <= next_respData;
            stale <= next_stale;
            busAddr <= next_busAddr;
            shadowAddr <= next_shadowAddr;
            memWe <= next_memWe;
            faultReg <= faultFlags;
            bootCnt <= next_bootCnt;
        end
    end

    // read address follows the pending index, so data settle while busy
    scmac_cfg_mem u_cfgMem (
        .mclk(mclk),
        .rst_n(rst_n),
        .we(memWe),
        .wAddr(pendIdx),
        .wData(pendData),
        .rAddr(pendIdx),
        .rData(memRData)
    );

    AST_WINDOW_ONLY: assert property (
        $rose(cmdModeActive) |-> $past(windowCnt) != '0)
        else $error("command mode entered outside power-on window");
    AST_ENTRY_BYTE: assert property (
        ($rose(cmdModeActive) && faultReg == 4'h0) |-> statusByte == 8'h81)
        else $error("entry response is not 0x81");
    AST_FOUR_BYTES: assert property (
        execPulse |-> rxCnt == 3'h3 && $past(stopCond))
        else $error("command run without a four-byte message");
    AST_ACK_DRIVE: assert property (
        (i2cState == I2C_RACK || i2cState == I2C_AACK) |-> !sdaOeN)
        else $error("byte not acknowledged");
    AST_BUSY_FIELD: assert property (
        (busyCnt != '0) |-> respCode == 2'h0)
        else $error("response field not busy while working");
    AST_RESP_BOUND: assert property (
        (pendOp == OP_READ || pendOp == OP_REV)
            |-> busyCnt <= CNT_W'(RESP_CYCLES))
        else $error("read response later than allowed");
    AST_OLD_ADDR: assert property (
        (cmdModeActive && $past(cmdModeActive)) |-> $stable(busAddr))
        else $error("bus address changed in command mode");
    AST_NEW_ADDR: assert property (
        $fell(cmdModeActive) |-> busAddr == $past(shadowAddr))
        else $error("stored address not taken at end of command mode");
    AST_RESUME: assert property (
        (execPulse && cmdModeActive && busyCnt == '0
            && cmdByte == 8'h80) |=> !cmdModeActive ##1 !cmdModeActive)
        else $error("resume command did not leave command mode");
    AST_MEM_WRITE: assert property (
        memWe |-> $past(pendOp) == OP_WRITE && $past(busyCnt) == CNT_W'(1))
        else $error("memory write outside write completion");
    AST_STATUS_FIRST: assert property (
        (i2cState == I2C_AACK && sclFall && rwBit && !startCond && !stopCond)
            |=> txShift == $past(statusByte))
        else $error("fetch does not start with status byte");
endmodule // scmac_cmd_interp
`default_nettype wire

// ### testbench/scmac_host_model.sv
// i2c bus master model standing in for the host controller
`timescale 1ns/1ps
`default_nettype none
module scmac_host_model (
    // pacing clock
    input wire logic mclk,
    // bus lines, sda released means pulled up
    output logic scl,
    output logic sdaRel,
    input wire logic sdaWire
);
    localparam int Q = 5; // quarter bit, above the slave sync delay
    initial begin
        scl = 1'b1;
        sdaRel = 1'b1;
    end
    task automatic tick(input int n);
        repeat (n) @(negedge mclk);
    endtask
    // sda changes while scl low, sampled mid-high
    task automatic bitx(input logic b, output logic s);
        sdaRel = b;
        tick(Q);
        scl = 1'b1;
        tick(Q);
        s = sdaWire;
        tick(Q);
        scl = 1'b0;
        tick(Q);
    endtask
    task automatic sendStart();
        tick(Q);
        sdaRel = 1'b0;
        tick(Q);
        scl = 1'b0;
        tick(Q);
    endtask
    task automatic sendStop();
        sdaRel = 1'b0;
        tick(Q);
        scl = 1'b1;
        tick(Q);
        sdaRel = 1'b1;
        tick(2 * Q);
    endtask
    task automatic wrByte(input logic [7:0] b, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) bitx(b[i], s);
        bitx(1'b1, s);
        ack = ~s;
    endtask
    // four-byte message; callers pass zero data for reads
    task automatic msg(input logic [6:0] adr, input logic [7:0] cmd,
                       input logic [15:0] dat, output logic ok);
        logic a0, a1, a2, a3;
        sendStart();
        wrByte({adr, 1'b0}, a0);
        wrByte(cmd, a1);
        wrByte(dat[15:8], a2);
        wrByte(dat[7:0], a3);
        sendStop();
        ok = a0 & a1 & a2 & a3;
    endtask
    // response fetch; nack on the last byte ends it early
    task automatic fetch(input logic [6:0] adr, input int n,
                         output logic [23:0] got, output logic ok);
        logic s;
        got = 24'h0;
        sendStart();
        wrByte({adr, 1'b1}, ok);
        for (int k = 0; k < n && ok; k++) begin
            for (int i = 0; i < 8; i++) begin
                bitx(1'b1, s);
                got = {got[22:0], s};
            end
            bitx(k == n - 1, s);
        end
        sendStop();
    endtask
endmodule // scmac_host_model
`default_nettype wire

// ### testbench/sensor_command_mode_address_change_test.sv
// self-checking bench for the command-mode interpreter
`timescale 1ns/1ps
`default_nettype none
module sensor_command_mode_address_change_test;
    import scmac_pkg::*;
    localparam int WIN = 2000;
    localparam int RSP = 20;
    localparam int WRC = 2000; // long enough to fetch while busy
    localparam logic [15:0] REV = 16'h00a5; // arbitrary value
    logic mclk = 1'b0;
    logic rst_n = 1'b0;
    logic [3:0] faultFlags = 4'h0;
    logic scl, sdaRel, sdaOut, sdaOeN, cmdModeActive, ok;
    logic [6:0] busAddr;
    logic [23:0] got;
    logic [6:0] adr = 7'h28; // address the host talks to
    wire sdaWire;
    int errors = 0;
    int tests_run = 0;
    // open-drain sda with pull-up
    assign sdaWire = sdaRel & ((sdaOeN !== 1'b0) | sdaOut);
    always #2 mclk = ~mclk;
    scmac_cmd_interp #(.WINDOW_CYCLES(WIN), .RESP_CYCLES(RSP),
        .WRITE_CYCLES(WRC), .REVISION(REV)) dut (.mclk(mclk),
        .rst_n(rst_n), .scl(scl), .sdaIn(sdaWire), .sdaOut(sdaOut),
        .sdaOeN(sdaOeN), .faultFlags(faultFlags),
        .cmdModeActive(cmdModeActive), .busAddr(busAddr));
    scmac_host_model host (.mclk(mclk), .scl(scl), .sdaRel(sdaRel),
        .sdaWire(sdaWire));
    task automatic check(input logic [23:0] seen, input logic [23:0] exp);
        tests_run++;
        if (seen !== exp) begin
            errors++;
            $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask
    task automatic test_done();
        $display("checks %0d, mismatches %0d", tests_run, errors);
        if (errors == 0 && tests_run > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    // message at the current address, then settle w cycles
    task automatic cmd(input logic [7:0] c, input logic [15:0] d,
                       input int w);
        host.msg(adr, c, d, ok);
        check(24'(ok), 24'h1);
        repeat (w) @(negedge mclk);
    endtask
    task automatic fetchChk(input logic [6:0] a, input int n,
                            input logic [23:0] exp);
        host.fetch(a, n, got, ok);
        check(got, exp);
    endtask
    // hang guard
    initial begin
        repeat (100000) @(posedge mclk);
        errors++;
        test_done();
    end
    initial begin
        repeat (2) @(negedge mclk);
        rst_n = 1'b1;
        check(24'(busAddr), 24'h28);
        cmd(8'ha0, 16'h0, RSP + 20);
        check(24'(cmdModeActive), 24'h1);
        fetchChk(7'h28, 1, 24'h81);
        cmd(8'h1c, 16'h0, RSP + 20);
        fetchChk(7'h28, 3, 24'h810028);
        $display("entry and address read done");
        for (int i = 0; i < 4; i++) begin
            faultFlags = 4'h1 << i;
            cmd(8'h00, 16'h0, RSP + 20);
            fetchChk(7'h28, 1, {16'h0, 2'b10, 4'h1 << i, 2'b01});
        end
        faultFlags = 4'h0;
        cmd(8'hb0, 16'h0, RSP + 20);
        fetchChk(7'h28, 3, {8'h81, REV});
        cmd(8'h60, 16'h0, RSP + 20);
        fetchChk(7'h28, 1, 24'h82);
        cmd(8'h43, 16'hbeef, WRC + 20);
        cmd(8'h03, 16'h0, RSP + 20);
        fetchChk(7'h28, 3, 24'h81beef);
        $display("diagnostics, revision and word access done");
        cmd(8'h5c, 16'h0031, 0);
        fetchChk(7'h28, 1, 24'h80);
        repeat (WRC) @(negedge mclk);
        fetchChk(7'h28, 1, 24'h81);
        check(24'(busAddr), 24'h28);
        cmd(8'h1c, 16'h0, RSP + 20);
        fetchChk(7'h28, 3, 24'h810031);
        cmd(8'h80, 16'h0, RSP + 20);
        check(24'(cmdModeActive), 24'h0);
        check(24'(busAddr), 24'h31);
        adr = 7'h31;
        fetchChk(7'h28, 1, 24'h0);
        fetchChk(7'h31, 1, 24'h01);
        fetchChk(7'h31, 1, 24'h41);
        $display("address change done");
        rst_n = 1'b0;
        repeat (2) @(negedge mclk);
        rst_n = 1'b1;
        repeat (4) @(negedge mclk);
        check(24'(busAddr), 24'h31);
        repeat (WIN + 50) @(negedge mclk);
        cmd(8'ha0, 16'h0, RSP + 20);
        check(24'(cmdModeActive), 24'h0);
        fetchChk(7'h31, 1, 24'h00);
        fetchChk(7'h31, 1, 24'h40);
        $display("late entry done");
        test_done();
    end
endmodule // sensor_command_mode_address_change_test
`default_nettype wire
